//--- rtl/hbr_pkg.sv
// shared constants and types for the bridge output and pwm map registers
`default_nettype none

package hbr_pkg;

	// register bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_BRIDGES = 4;
	localparam int NUM_PINS = 4;
	localparam int FIELD_W = 2;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_BRIDGE_OUTPUT_STATE = 8'h09;
	localparam logic [ADDR_W-1:0] OFS_HBRIDGE_SOFT_INPUTS = 8'h0A;
	localparam logic [ADDR_W-1:0] OFS_PWM_SOURCE_MAP = 8'h0B;

	// reset values
	localparam logic [DATA_W-1:0] RST_BRIDGE_OUTPUT_STATE = 8'h00;
	localparam logic [DATA_W-1:0] RST_HBRIDGE_SOFT_INPUTS = 8'h00;
	localparam logic [DATA_W-1:0] RST_PWM_SOURCE_MAP = 8'h05;

	// writable bits of the soft input register, bits 4 and 0 stay zero
	localparam logic [DATA_W-1:0] SOFT_WRITE_MASK = 8'hEE;

	// soft input register field positions
	localparam int SOFT_IN_ONE_BIT = 7;
	localparam int SOFT_IN_TWO_BIT = 6;
	localparam int PAIR_A_FLOAT_BIT = 5;
	localparam int SOFT_IN_THREE_BIT = 3;
	localparam int SOFT_IN_FOUR_BIT = 2;
	localparam int PAIR_B_FLOAT_BIT = 1;

	// lsb of the two-bit field of bridge 1..4 (index 0..3) in state and map registers
	localparam int BRIDGE_FIELD_LSB [NUM_BRIDGES] = '{6, 4, 2, 0};

	// bridge control mode, held in a neighbouring register
	typedef enum logic [1:0] {
		MODE_INDEPENDENT = 2'h0,
		MODE_PHASE_ENABLE = 2'h1,
		MODE_HBRIDGE_PWM = 2'h2,
		MODE_SOLENOID = 2'h3
	} hbr_mode_type;

	// per-bridge output state in independent mode
	typedef enum logic [1:0] {
		STATE_FLOAT = 2'h0,
		STATE_LOW = 2'h1,
		STATE_HIGH = 2'h2,
		STATE_PWM = 2'h3
	} hbr_state_type;

endpackage

`default_nettype wire

//--- rtl/hbr_drive_if.sv
// gate drive request of one half-bridge between the decoders and the top
`default_nettype none

interface hbr_drive_if;
	logic highOn;
	logic lowOn;
	modport src (output highOn, output lowOn);
	modport snk (input highOn, input lowOn);
endinterface

`default_nettype wire

//--- rtl/hbr_half_bridge.sv
// independent-mode decoder for one half-bridge
`default_nettype none

module hbr_half_bridge (
	input wire hbr_pkg::hbr_state_type state,
	input wire logic [hbr_pkg::NUM_PINS-1:0] pwmPins,
	input wire logic [hbr_pkg::FIELD_W-1:0] pwmSrc,
	input wire logic driveSide,
	input wire logic freewheel,
	hbr_drive_if.src drv
);
	import hbr_pkg::*;

	// selected pwm input and the switch it drives
	wire pwmLevel = pwmPins[pwmSrc]; // R13
	wire pwmOnHigh = driveSide ? (!freewheel && !pwmLevel) : pwmLevel; // R19 R20
	wire pwmOnLow = driveSide ? pwmLevel : (!freewheel && !pwmLevel); // R19 R20

	// state decode; float keeps both gates pulled down
	assign drv.highOn = (state == STATE_HIGH) || ((state == STATE_PWM) && pwmOnHigh); // R1 R4
	assign drv.lowOn = (state == STATE_LOW) || ((state == STATE_PWM) && pwmOnLow); // R1 R4

endmodule

`default_nettype wire

//--- rtl/hbr_hbridge_pair.sv
// h-bridge decoder for one pair of half-bridges
`default_nettype none

module hbr_hbridge_pair (
	input wire hbr_pkg::hbr_mode_type mode,
	input wire logic sigOne,
	input wire logic sigTwo,
	input wire logic floatReq,
	input wire logic freewheelHigh,
	hbr_drive_if.src first,
	hbr_drive_if.src second
);
	import hbr_pkg::*;

	// brake on the side chosen by the pair freewheel bit
	wire brakeHigh = freewheelHigh;
	wire brakeLow = !freewheelHigh;
	wire pe = (mode == MODE_PHASE_ENABLE);
	wire pw = (mode == MODE_HBRIDGE_PWM);
	wire so = (mode == MODE_SOLENOID);

	// phase/enable: enable low brakes, phase picks the direction
	wire peAHigh = sigOne ? sigTwo : brakeHigh;
	wire peALow = sigOne ? !sigTwo : brakeLow;
	wire peBHigh = sigOne ? !sigTwo : brakeHigh;
	wire peBLow = sigOne ? sigTwo : brakeLow;

	// pwm mode: 00 coasts, 01 and 10 drive, 11 brakes
	wire pwAHigh = (sigOne && !sigTwo) || (sigOne && sigTwo && brakeHigh);
	wire pwALow = (!sigOne && sigTwo) || (sigOne && sigTwo && brakeLow);
	wire pwBHigh = (!sigOne && sigTwo) || (sigOne && sigTwo && brakeHigh);
	wire pwBLow = (sigOne && !sigTwo) || (sigOne && sigTwo && brakeLow);

	// float request overrides every mode
	assign first.highOn = !floatReq && ((pe && peAHigh) || (pw && pwAHigh) || (so && sigOne)); // R9 R10
	assign first.lowOn = !floatReq && ((pe && peALow) || (pw && pwALow)); // R9 R10
	assign second.highOn = !floatReq && ((pe && peBHigh) || (pw && pwBHigh)); // R9 R10
	assign second.lowOn = !floatReq && ((pe && peBLow) || (pw && pwBLow) || (so && sigTwo)); // R9 R10

endmodule

`default_nettype wire

//--- rtl/hbr_bridge_regs.sv
// bridge output state, h-bridge soft input and pwm map registers with gate decode
// Behaviour
// R1: bridge 1 bits 7-6: 00 float, 01 low on, 10 high on, 11 pwm.
// R2: bridges 2,3,4 use bits 5-4, 3-2, 1-0 with the same decode.
// R3: state register drives the gates only in independent mode 00.
// R4: state 11 drives bridge from its mapped pwm with drive side and freewheel.
// R5: state register at offset 9h, reset 0h, all bridges floating.
// R6: soft input register drives both pairs only in modes 01, 10, 11.
// R7: bit 7 soft input one/enable, bit 6 soft input two/phase, when selected.
// R8: bit 3 soft input three/enable, bit 2 soft input four/phase, when selected.
// R9: bit 5 set floats bridges 1 and 2, clear lets them follow inputs.
// R10: bit 1 set floats bridges 3 and 4, clear lets them follow inputs.
// R11: soft input register at offset Ah, reset 0h, bits 4 and 0 read zero.
// R12: pwm map picks each bridge's pwm input, independent mode only.
// R13: bridge 1 map bits 7-6: 00 input one up to 11 input four.
// R14: bridge 2 map bits 5-4, same encoding, reset 00.
// R15: bridges 3 and 4 map bits 3-2 and 1-0, reset 01.
// R16: pwm map register at offset Bh, reset 5h.
// R17: mode 00 independent, 01 phase/enable, 10 h-bridge pwm, 11 solenoid.
// R18: each h-bridge input comes from its pin at select 0, soft bit at 1.
// R19: drive side 0 pwm drives high switch, 1 drives low switch.
// R20: freewheel 0 drives inverted pwm on opposite switch, 1 leaves it off.
// R21: fields of an inactive mode keep their values and do not steer gates.
//
// Chosen here: the address-and-strobe port.
`default_nettype none

module hbr_bridge_regs (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [hbr_pkg::ADDR_W-1:0] regAddr,
	input wire logic [hbr_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [hbr_pkg::DATA_W-1:0] regRdata,
	input wire logic [1:0] bridgeCtrlMode,
	input wire logic [3:0] inputSourceSel,
	input wire logic [hbr_pkg::NUM_BRIDGES-1:0] bridgeDriveSide,
	input wire logic [hbr_pkg::NUM_BRIDGES-1:0] bridgeFreewheel,
	input wire logic [1:0] pairFreewheelHigh,
	input wire logic pwmPinOne,
	input wire logic pwmPinTwo,
	input wire logic pwmPinThree,
	input wire logic pwmPinFour,
	output logic [hbr_pkg::NUM_BRIDGES-1:0] highGateOut,
	output logic [hbr_pkg::NUM_BRIDGES-1:0] lowGateOut
);
	import hbr_pkg::*;

	// stored registers
	logic [DATA_W-1:0] bridgeOutputState_q;
	logic [DATA_W-1:0] hbridgeSoftInputs_q;
	logic [DATA_W-1:0] pwmSourceMap_q;
	logic [DATA_W-1:0] regRdata_q;
	logic [DATA_W-1:0] regRdata_d;
	logic [NUM_BRIDGES-1:0] highGate_q;
	logic [NUM_BRIDGES-1:0] lowGate_q;
	logic [NUM_BRIDGES-1:0] highGate_d;
	logic [NUM_BRIDGES-1:0] lowGate_d;

	// address decode
	wire hitState = (regAddr == OFS_BRIDGE_OUTPUT_STATE);
	wire hitSoft = (regAddr == OFS_HBRIDGE_SOFT_INPUTS);
	wire hitMap = (regAddr == OFS_PWM_SOURCE_MAP);
	wire wrState = regWr && hitState; // R5
	wire wrSoft = regWr && hitSoft; // R11
	wire wrMap = regWr && hitMap; // R16

	// register writes; each register only moves on its own write strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bridgeOutputState_q <= RST_BRIDGE_OUTPUT_STATE; // R5
			hbridgeSoftInputs_q <= RST_HBRIDGE_SOFT_INPUTS; // R11
			pwmSourceMap_q <= RST_PWM_SOURCE_MAP; // R14 R15 R16
		end else begin
			if (wrState) begin
				bridgeOutputState_q <= regWdata; // R21
			end
			if (wrSoft) begin
				hbridgeSoftInputs_q <= regWdata & SOFT_WRITE_MASK; // R11
			end
			if (wrMap) begin
				pwmSourceMap_q <= regWdata; // R21
			end
		end
	end

	// read mux; unmapped offsets and idle cycles answer zero
	always_comb begin
		regRdata_d = '0;
		if (regRd && hitState) begin
			regRdata_d = bridgeOutputState_q;
		end else if (regRd && hitSoft) begin
			regRdata_d = hbridgeSoftInputs_q; // R11
		end else if (regRd && hitMap) begin
			regRdata_d = pwmSourceMap_q;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata_q <= '0;
		end else begin
			regRdata_q <= regRdata_d;
		end
	end

	assign regRdata = regRdata_q;

	// mode decode
	hbr_mode_type mode;
	assign mode = hbr_mode_type'(bridgeCtrlMode); // R17
	wire indepMode = (mode == MODE_INDEPENDENT); // R3 R12

	// pins and soft bits in input order one..four
	wire [NUM_PINS-1:0] pinVec = {pwmPinFour, pwmPinThree, pwmPinTwo, pwmPinOne};
	wire [3:0] softVec = {
		hbridgeSoftInputs_q[SOFT_IN_FOUR_BIT],
		hbridgeSoftInputs_q[SOFT_IN_THREE_BIT],
		hbridgeSoftInputs_q[SOFT_IN_TWO_BIT],
		hbridgeSoftInputs_q[SOFT_IN_ONE_BIT]
	}; // R7 R8

	// pin or soft bit per h-bridge input
	wire [3:0] hbInput = (inputSourceSel & softVec) | (~inputSourceSel & pinVec); // R18

	// per-bridge independent decode
	hbr_drive_if indepDrv [NUM_BRIDGES] ();
	hbr_drive_if pairDrv [NUM_BRIDGES] ();

	for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
		wire [FIELD_W-1:0] stateField = bridgeOutputState_q[BRIDGE_FIELD_LSB[b] +: FIELD_W]; // R1 R2
		wire [FIELD_W-1:0] mapField = pwmSourceMap_q[BRIDGE_FIELD_LSB[b] +: FIELD_W]; // R13 R14 R15
		hbr_half_bridge u_half (
			.state(hbr_state_type'(stateField)),
			.pwmPins(pinVec),
			.pwmSrc(mapField),
			.driveSide(bridgeDriveSide[b]),
			.freewheel(bridgeFreewheel[b]),
			.drv(indepDrv[b])
		);
	end

	// pair decode for bridges 1/2 and 3/4
	hbr_hbridge_pair u_pair_a (
		.mode(mode),
		.sigOne(hbInput[0]),
		.sigTwo(hbInput[1]),
		.floatReq(hbridgeSoftInputs_q[PAIR_A_FLOAT_BIT]),
		.freewheelHigh(pairFreewheelHigh[0]),
		.first(pairDrv[0]),
		.second(pairDrv[1])
	);

	hbr_hbridge_pair u_pair_b (
		.mode(mode),
		.sigOne(hbInput[2]),
		.sigTwo(hbInput[3]),
		.floatReq(hbridgeSoftInputs_q[PAIR_B_FLOAT_BIT]),
		.freewheelHigh(pairFreewheelHigh[1]),
		.first(pairDrv[2]),
		.second(pairDrv[3])
	);

	// gate selection by mode; the other mode's fields are ignored, not cleared
	for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_sel
		assign highGate_d[b] = indepMode ? indepDrv[b].highOn : pairDrv[b].highOn; // R3 R6 R21
		assign lowGate_d[b] = indepMode ? indepDrv[b].lowOn : pairDrv[b].lowOn; // R3 R6 R21
	end

	// gate flops; one cycle of latency keeps glitches off the drivers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			highGate_q <= '0; // R5
			lowGate_q <= '0; // R5
		end else begin
			highGate_q <= highGate_d;
			lowGate_q <= lowGate_d;
		end
	end

	assign highGateOut = highGate_q;
	assign lowGateOut = lowGate_q;

	// helper values for the checks below
	wire [FIELD_W-1:0] chkState1 = bridgeOutputState_q[7:6];
	wire [FIELD_W-1:0] chkState4 = bridgeOutputState_q[1:0];
	wire chkPin1 = pinVec[pwmSourceMap_q[7:6]];
	wire chkPin4 = pinVec[pwmSourceMap_q[1:0]];
	wire [FIELD_W-1:0] chkState2 = bridgeOutputState_q[5:4];
	wire chkPin2 = pinVec[pwmSourceMap_q[5:4]];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// read answer
	a_read_answer_value: assert property ( // R5 R11 R16
		regRd && hitMap && !regWr |=> regRdata == $past(pwmSourceMap_q)
	) else $error("map register read returned wrong data");

	a_read_idle_zero: assert property (
		!regRd |=> regRdata == '0
	) else $error("read data present without read strobe");

	// reserved soft input bits
	a_soft_reserved_zero: assert property ( // R11
		hbridgeSoftInputs_q[4] == 1'b0 && hbridgeSoftInputs_q[0] == 1'b0
	) else $error("reserved soft input bit is set");

	// map write lands next cycle
	a_map_write_lands: assert property ( // R16
		wrMap |=> pwmSourceMap_q == $past(regWdata)
	) else $error("map register write lost");

	// independent mode states for bridge 1
	a_float_state_off: assert property ( // R1
		indepMode && chkState1 == STATE_FLOAT |=> !highGateOut[0] && !lowGateOut[0]
	) else $error("floating bridge 1 drives a gate");

	a_low_state_drive: assert property ( // R1
		indepMode && chkState1 == STATE_LOW |=> lowGateOut[0] && !highGateOut[0]
	) else $error("bridge 1 low state wrong");

	a_high_state_drive: assert property ( // R1
		indepMode && chkState1 == STATE_HIGH |=> highGateOut[0] && !lowGateOut[0]
	) else $error("bridge 1 high state wrong");

	// bridge 4 field position
	a_bridge4_high_state: assert property ( // R2
		indepMode && chkState4 == STATE_HIGH |=> highGateOut[3] && !lowGateOut[3]
	) else $error("bridge 4 high state wrong");

	// pwm follow through the map, high side driven, active freewheel
	a_pwm_follow_map: assert property ( // R4 R13 R19 R20
		indepMode && chkState1 == STATE_PWM && !bridgeDriveSide[0] && !bridgeFreewheel[0]
		|=> highGateOut[0] == $past(chkPin1) && lowGateOut[0] == !$past(chkPin1)
	) else $error("bridge 1 pwm mapping wrong");

	// low side driven, passive freewheel keeps high switch off
	a_pwm_passive_low: assert property ( // R19 R20 R15
		indepMode && chkState4 == STATE_PWM && bridgeDriveSide[3] && bridgeFreewheel[3]
		|=> lowGateOut[3] == $past(chkPin4) && !highGateOut[3]
	) else $error("bridge 4 passive low-side pwm wrong");

	// pair float bits
	a_pair_a_float: assert property ( // R6 R9
		!indepMode && hbridgeSoftInputs_q[PAIR_A_FLOAT_BIT]
		|=> highGateOut[1:0] == 2'h0 && lowGateOut[1:0] == 2'h0
	) else $error("pair a not floating");

	a_pair_b_float: assert property ( // R10
		!indepMode && hbridgeSoftInputs_q[PAIR_B_FLOAT_BIT]
		|=> highGateOut[3:2] == 2'h0 && lowGateOut[3:2] == 2'h0
	) else $error("pair b not floating");

	// soft enable and phase drive pair a forward
	a_soft_phase_enable: assert property ( // R7 R18
		mode == MODE_PHASE_ENABLE && inputSourceSel[1:0] == 2'h3
		&& hbridgeSoftInputs_q[7:5] == 3'h6
		|=> highGateOut[0] && lowGateOut[1] && !lowGateOut[0] && !highGateOut[1]
	) else $error("soft phase/enable drive wrong");

	// pins used when select is clear
	a_pin_phase_enable: assert property ( // R8 R18
		mode == MODE_PHASE_ENABLE && inputSourceSel[3:2] == 2'h0
		&& !hbridgeSoftInputs_q[PAIR_B_FLOAT_BIT] && pwmPinThree && !pwmPinFour
		|=> lowGateOut[2] && highGateOut[3]
	) else $error("pin phase/enable drive wrong");

	// inactive mode leaves state register untouched
	a_inactive_state_hold: assert property ( // R21 R12
		!indepMode && !wrState && !wrMap |=> $stable(bridgeOutputState_q) && $stable(pwmSourceMap_q)
	) else $error("inactive mode register changed");

	// register contents and read-back of the other two registers
	a_state_write_lands: assert property ( // R5
		wrState |=> bridgeOutputState_q == $past(regWdata)
	) else $error("state register write lost");

	a_soft_write_masked: assert property ( // R11
		wrSoft |=> hbridgeSoftInputs_q == ($past(regWdata) & SOFT_WRITE_MASK)
	) else $error("soft input write not masked");

	a_read_state_value: assert property ( // R5
		regRd && hitState && !regWr |=> regRdata == $past(bridgeOutputState_q)
	) else $error("state register read returned wrong data");

	a_read_soft_value: assert property ( // R11
		regRd && hitSoft && !regWr |=> regRdata == $past(hbridgeSoftInputs_q)
	) else $error("soft input read returned wrong data");

	// bridge 2 and 3 field positions and the bridge 2 map field
	a_bridge2_low_state: assert property ( // R2
		indepMode && chkState2 == STATE_LOW |=> lowGateOut[1] && !highGateOut[1]
	) else $error("bridge 2 low state wrong");

	a_bridge3_float_state: assert property ( // R2
		indepMode && bridgeOutputState_q[3:2] == STATE_FLOAT
		|=> !highGateOut[2] && !lowGateOut[2]
	) else $error("floating bridge 3 drives a gate");

	a_bridge2_map_follow: assert property ( // R14
		indepMode && chkState2 == STATE_PWM && !bridgeDriveSide[1]
		|=> highGateOut[1] == $past(chkPin2)
	) else $error("bridge 2 pwm mapping wrong");

	// both switches of one leg on at once would short the supply
	a_no_shoot_through: assert property ( // R1 R20
		(highGateOut & lowGateOut) == '0
	) else $error("high and low gate on together");

	// h-bridge pwm with both inputs low coasts pair a
	a_hbridge_pwm_coast: assert property ( // R17
		mode == MODE_HBRIDGE_PWM && hbInput[1:0] == 2'h0
		|=> highGateOut[1:0] == 2'h0 && lowGateOut[1:0] == 2'h0
	) else $error("h-bridge pwm coast wrong");

	// solenoid: first high follows input one, second low follows input two
	a_solenoid_pair_a: assert property ( // R17
		mode == MODE_SOLENOID && !hbridgeSoftInputs_q[PAIR_A_FLOAT_BIT]
		|=> highGateOut[0] == $past(hbInput[0]) && lowGateOut[1] == $past(hbInput[1])
		&& !lowGateOut[0] && !highGateOut[1]
	) else $error("solenoid pair a drive wrong");

	// main scenarios
	c_pwm_state_used: cover property (
		indepMode && chkState1 == STATE_PWM ##1 highGateOut[0] ##1 !highGateOut[0]
	);

	c_phase_enable_drive: cover property (
		mode == MODE_PHASE_ENABLE && !hbridgeSoftInputs_q[PAIR_A_FLOAT_BIT] ##1 highGateOut[0]
	);

	c_pair_float: cover property (
		wrSoft && regWdata[PAIR_A_FLOAT_BIT] && !indepMode
	);

	c_map_read: cover property (
		regRd && hitMap ##1 regRdata != '0
	);

	c_pair_brake_high: cover property (
		mode == MODE_PHASE_ENABLE && pairFreewheelHigh[0] ##1 highGateOut[1:0] == 2'h3
	);

endmodule

`default_nettype wire

//--- test/hbr_pwm_source.sv
// host pwm source model driving the four pwm input pins
`default_nettype none

module hbr_pwm_source (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] pinCmd,
	output logic pwmPinOne,
	output logic pwmPinTwo,
	output logic pwmPinThree,
	output logic pwmPinFour
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] pinQ;

	// pins change only on the clock edge, as the host's timer outputs do
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinQ <= 4'h0;
		end else begin
			pinQ <= pinCmd;
		end
	end

	// bit 0 is pin one
	assign pwmPinOne = pinQ[0];
	assign pwmPinTwo = pinQ[1];
	assign pwmPinThree = pinQ[2];
	assign pwmPinFour = pinQ[3];
endmodule

`default_nettype wire

//--- test/hbr_bridge_regs_bench.sv
// self-checking bench for the bridge state, soft input and pwm map registers
`default_nettype none

`define CHK(got, exp) begin \
	totalChecks++; \
	if ((got) !== (exp)) begin \
		nMismatch++; \
		$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end

module hbr_bridge_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import hbr_pkg::*;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] regAddr = 8'h00;
	logic [DATA_W-1:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [DATA_W-1:0] regRdata;
	logic [1:0] mode = 2'h0;
	logic [3:0] srcSel = 4'h0;
	logic [3:0] driveSide = 4'h0;
	logic [3:0] freewheel = 4'h0;
	logic [1:0] pairFw = 2'h0;
	logic [3:0] pinCmd = 4'h0;
	logic pinOne, pinTwo, pinThree, pinFour;
	logic [3:0] highGate, lowGate;
	logic drv, opp;
	int nMismatch = 0;
	int totalChecks = 0;
	int s;

	// 4 ns period
	always #2 clk = ~clk;

	hbr_pwm_source u_hbr_pwm_source (.clk(clk), .resetn(resetn), .pinCmd(pinCmd),
		.pwmPinOne(pinOne), .pwmPinTwo(pinTwo), .pwmPinThree(pinThree), .pwmPinFour(pinFour));

	// brake side select driven so both brake sides get exercised
	hbr_bridge_regs u_hbr_bridge_regs (.clk(clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.bridgeCtrlMode(mode), .inputSourceSel(srcSel), .bridgeDriveSide(driveSide),
		.bridgeFreewheel(freewheel), .pairFreewheelHigh(pairFw), .pwmPinOne(pinOne),
		.pwmPinTwo(pinTwo), .pwmPinThree(pinThree), .pwmPinFour(pinFour),
		.highGateOut(highGate), .lowGateOut(lowGate));

	// one-cycle write strobe; leading edge wait keeps strobes from colliding
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`CHK(regRdata, e)
	endtask

	// neighbouring-register fields and pin levels
	task automatic setIn(input logic [1:0] m, input logic [3:0] sel, input logic [3:0] ds,
		input logic [3:0] fw, input logic [3:0] pins);
		@(posedge clk);
		mode <= m;
		srcSel <= sel;
		driveSide <= ds;
		freewheel <= fw;
		pinCmd <= pins;
	endtask

	// pin model and gate register add latency, so allow three edges
	task automatic gchk(input logic [3:0] h, input logic [3:0] l);
		repeat (3) @(posedge clk);
		#1;
		`CHK(highGate, h)
		`CHK(lowGate, l)
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		tally_and_finish;
	end

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		gchk(4'h0, 4'h0);
		rdchk(8'h09, 8'h00);
		rdchk(8'h0A, 8'h00);
		rdchk(8'h0B, 8'h05);
		// reserved soft bits stay zero; unmapped offset reads zero
		wr(8'h0A, 8'hFF);
		rdchk(8'h0A, 8'hEE);
		wr(8'h0C, 8'h5A);
		rdchk(8'h0C, 8'h00);
		wr(8'h0A, 8'h00);
		// float, low and high in every field
		for (s = 0; s < 3; s++) begin
			wr(8'h09, {4{s[1:0]}});
			gchk((s == 2) ? 4'hF : 4'h0, (s == 1) ? 4'hF : 4'h0);
		end
		// mixed fields: low, high, float, pwm from reset map (pin two)
		setIn(2'h0, 4'h0, 4'h0, 4'h0, 4'h2);
		wr(8'h09, 8'h63);
		gchk(4'hA, 4'h1);
		// every map code, one-hot pins so only the chosen pin is high
		wr(8'h09, 8'hFF);
		for (s = 0; s < 4; s++) begin
			wr(8'h0B, {4{s[1:0]}});
			setIn(2'h0, 4'h0, 4'h0, 4'h0, 4'h1 << s);
			gchk(4'hF, 4'h0);
			setIn(2'h0, 4'h0, 4'h0, 4'h0, ~(4'h1 << s));
			gchk(4'h0, 4'hF);
		end
		// drive side and freewheel against pin one
		wr(8'h0B, 8'h00);
		for (s = 0; s < 8; s++) begin
			setIn(2'h0, 4'h0, {4{s[2]}}, {4{s[1]}}, {4{s[0]}});
			drv = s[0];
			opp = !s[1] && !s[0];
			gchk(s[2] ? {4{opp}} : {4{drv}}, s[2] ? {4{drv}} : {4{opp}});
		end
		// h-bridge pwm from soft bits, then each float bit
		wr(8'h0A, 8'h84);
		setIn(2'h2, 4'hF, 4'h0, 4'h0, 4'h0);
		gchk(4'h9, 4'h6);
		wr(8'h0A, 8'hA4);
		gchk(4'h8, 4'h4);
		wr(8'h0A, 8'h86);
		gchk(4'h1, 4'h2);
		// same drive taken from pins instead
		wr(8'h0A, 8'h00);
		setIn(2'h2, 4'h0, 4'h0, 4'h0, 4'h9);
		gchk(4'h9, 4'h6);
		setIn(2'h1, 4'h0, 4'h0, 4'h0, 4'h9);
		gchk(4'h2, 4'hD);
		setIn(2'h3, 4'h0, 4'h0, 4'h0, 4'h9);
		gchk(4'h1, 4'h8);
		// soft enable/phase on pair a, pins on pair b, then brake on the high sides
		setIn(2'h1, 4'h3, 4'h0, 4'h0, 4'h4);
		wr(8'h0A, 8'hC0);
		gchk(4'h9, 4'h6);
		wr(8'h0A, 8'h00);
		setIn(2'h1, 4'h3, 4'h0, 4'h0, 4'h0);
		pairFw <= 2'h3;
		gchk(4'hF, 4'h0);
		// back to independent mode: floats in soft register must not matter
		wr(8'h0A, 8'h22);
		setIn(2'h0, 4'hF, 4'h0, 4'h0, 4'h9);
		gchk(4'hF, 4'h0);
		rdchk(8'h09, 8'hFF);
		tally_and_finish;
	end
endmodule

`default_nettype wire
